// ---- rtl/scan_clock_consts.vh ----
// Constants for the scan test clock gating block
`ifndef SCAN_CLOCK_CONSTS_VH
`define SCAN_CLOCK_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MODE_ONE 12'h000
`define OFS_ENABLES 12'h004
`define OFS_SCAN_LENGTH 12'h008
`define OFS_STATUS 12'h00c
`define OFS_BITS 12

// ----------------------------------------
// Mode register one fields
// ----------------------------------------
`define MODE_TDO_NOT_FULL_IE 7
`define MODE_TDI_NOT_EMPTY_IE 6
`define MODE_LENGTH_IE 5
`define MODE_PATTERN_GEN 4
`define MODE_SIG_COMPACT 3
`define MODE_FREEZE_EN 2
`define MODE_WIDTH 8
`define MODE_RESET 8'h00

// ----------------------------------------
// Enable register fields
// ----------------------------------------
`define EN_TDO 0
`define EN_TDI 1
`define EN_SEL_A 2
`define EN_SEL_B 3
`define EN_LENGTH 4
`define EN_WIDTH 5
`define EN_RESET 5'h00

// ----------------------------------------
// Register select codes of the host wait logic
// ----------------------------------------
`define SEL_TDO 3'h0
`define SEL_TDI 3'h1
`define SEL_MODE_A 3'h2
`define SEL_MODE_B 3'h3

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define STAT_CLOCK_ENABLE 0
`define STAT_LOADED 1
`define STAT_TERMINAL 2
`define STAT_FREEZE 3
`define STAT_BIT_COUNT_LSB 4
`define STAT_BIT_COUNT_MSB 6
`define STAT_STOP_TDO 7
`define STAT_STOP_TDI 8
`define STAT_STOP_SELECT 9
`define STAT_STOP_LENGTH 10

// ----------------------------------------
// Counter widths and values
// ----------------------------------------
`define LENGTH_WIDTH 32
`define BIT_COUNT_WIDTH 3
`define BIT_COUNT_LAST 3'h7
`define BIT_COUNT_ZERO 3'h0
`define LENGTH_ZERO 32'h00000000
`define LENGTH_ONE 32'h00000001

`endif

// ---- rtl/scan_length_counters.v ----
// Scan length counter and bit-in-byte counter
`timescale 1ns/10ps
`default_nettype none
`include "scan_clock_consts.vh"

module scan_length_counters #(
  parameter LENGTH_WIDTH = `LENGTH_WIDTH
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire load,
  input wire [LENGTH_WIDTH-1:0] load_value,
  input wire length_enable,
  input wire step,
  // State
  output reg [LENGTH_WIDTH-1:0] scan_length_counter,
  output reg loaded,
  output wire terminal,
  output reg [`BIT_COUNT_WIDTH-1:0] bit_in_byte_counter,
  output wire half_swap
);

  wire length_step;
  wire reach_terminal;

  // ----------------------------------------
  // Scan length count down
  // ----------------------------------------
  assign terminal = loaded & (scan_length_counter == {LENGTH_WIDTH{1'b0}});
  assign length_step = step & length_enable & loaded & ~terminal;
  assign reach_terminal = length_step & (scan_length_counter == {{(LENGTH_WIDTH-1){1'b0}}, 1'b1});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_length_counter <= {LENGTH_WIDTH{1'b0}};
      loaded <= 1'b0;
    end else if (load) begin
      scan_length_counter <= load_value;
      loaded <= 1'b1;
    end else if (length_step) begin
      scan_length_counter <= scan_length_counter - {{(LENGTH_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Byte alignment
  // ----------------------------------------
  assign half_swap = (step & (bit_in_byte_counter == `BIT_COUNT_LAST)) | (length_enable & reach_terminal);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_in_byte_counter <= `BIT_COUNT_ZERO;
    end else if (length_enable & reach_terminal) begin
      bit_in_byte_counter <= `BIT_COUNT_ZERO;
    end else if (step) begin
      bit_in_byte_counter <= bit_in_byte_counter + 3'h1;
    end
  end

endmodule // scan_length_counters

`default_nettype wire

// ---- rtl/scan_clock_gating_control.v ----
// Scan test clock gating, interrupt and host wait control
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "scan_clock_consts.vh"

module scan_clock_gating_control #(
  parameter LENGTH_WIDTH = `LENGTH_WIDTH
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Shifter status
  input wire tdo_full,
  input wire tdo_empty,
  input wire tdo_seed_loaded,
  input wire tdi_full,
  input wire tdi_empty,
  input wire tdi_init_loaded,
  input wire sel_a_full,
  input wire sel_a_empty,
  input wire sel_b_full,
  input wire sel_b_empty,
  // Host parallel cycle
  input wire host_cycle,
  input wire host_read,
  input wire [2:0] reg_select,
  input wire write_sync_busy,
  input wire read_sync_busy,
  output reg host_wait,
  // Freeze pin
  input wire sample_hold_input,
  // Shifter control
  output reg tdo_enable,
  output reg tdi_enable,
  output reg sel_a_enable,
  output reg sel_b_enable,
  output reg pattern_generator_mode,
  output reg signature_compaction_mode,
  output reg shift_strobe,
  output reg half_swap,
  // Link and interrupt
  output reg test_clock,
  output reg interrupt
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [`MODE_WIDTH-1:0] mode_register_one;
  reg [`EN_WIDTH-1:0] enables;
  reg freeze_meta;
  reg freeze_sync;
  reg clock_phase;
  reg clock_enable;
  reg next_host_wait;
  reg next_interrupt;
  reg [31:0] read_value;
  reg read_hit;
  reg [31:0] status_word;
  wire access;
  wire write_now;
  wire read_now;
  wire [`OFS_BITS-1:0] offset;
  wire length_load;
  wire stop_clock;
  wire rise;
  wire freeze_active;
  wire [LENGTH_WIDTH-1:0] length_count;
  wire length_loaded;
  wire length_terminal;
  wire [`BIT_COUNT_WIDTH-1:0] bit_count;
  wire swap;
  wire stop_tdo;
  wire stop_tdi;
  wire stop_select;
  wire stop_length;
  wire tdo_space_event;
  wire tdi_data_event;
  wire length_event;
  wire read_hold;
  wire write_hold;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function is_offset;
    input [`OFS_BITS-1:0] addr;
    input [`OFS_BITS-1:0] target;
    begin
      is_offset = (addr == target);
    end
  endfunction

  assign offset = paddr[`OFS_BITS-1:0];
  assign access = psel & penable & ~pready;
  assign write_now = access & pwrite;
  assign read_now = access & ~pwrite;
  assign length_load = write_now & is_offset(offset, `OFS_SCAN_LENGTH);

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always @* begin
    status_word = 32'h00000000;
    status_word[`STAT_CLOCK_ENABLE] = clock_enable;
    status_word[`STAT_LOADED] = length_loaded;
    status_word[`STAT_TERMINAL] = length_terminal;
    status_word[`STAT_FREEZE] = freeze_active;
    status_word[`STAT_BIT_COUNT_MSB:`STAT_BIT_COUNT_LSB] = bit_count;
    status_word[`STAT_STOP_TDO] = stop_tdo;
    status_word[`STAT_STOP_TDI] = stop_tdi;
    status_word[`STAT_STOP_SELECT] = stop_select;
    status_word[`STAT_STOP_LENGTH] = stop_length;
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  always @* begin
    read_value = 32'h00000000;
    read_hit = 1'b1;
    if (is_offset(offset, `OFS_MODE_ONE)) begin
      read_value[`MODE_WIDTH-1:0] = mode_register_one;
    end else if (is_offset(offset, `OFS_ENABLES)) begin
      read_value[`EN_WIDTH-1:0] = enables;
    end else if (is_offset(offset, `OFS_SCAN_LENGTH)) begin
      read_value[LENGTH_WIDTH-1:0] = length_count;
    end else if (is_offset(offset, `OFS_STATUS)) begin
      read_value = status_word;
    end else begin
      read_hit = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access & ~read_hit;
      if (read_now) begin
        prdata <= read_value;
      end else if (access) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_register_one <= `MODE_RESET;
      enables <= `EN_RESET;
    end else if (write_now) begin
      if (is_offset(offset, `OFS_MODE_ONE)) begin
        mode_register_one <= pwdata[`MODE_WIDTH-1:0];
      end
      if (is_offset(offset, `OFS_ENABLES)) begin
        enables <= pwdata[`EN_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------
  // Freeze pin synchroniser
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze_meta <= 1'b0;
      freeze_sync <= 1'b0;
    end else begin
      freeze_meta <= sample_hold_input;
      freeze_sync <= freeze_meta;
    end
  end

  // ----------------------------------------
  // Freeze override
  // ----------------------------------------
  assign freeze_active = freeze_sync & mode_register_one[`MODE_FREEZE_EN];

  // ----------------------------------------
  // Stop conditions
  // ----------------------------------------
  assign stop_tdo = enables[`EN_TDO] & (tdo_empty
    | (mode_register_one[`MODE_PATTERN_GEN] & ~tdo_seed_loaded));
  assign stop_tdi = enables[`EN_TDI] & (tdi_full
    | (mode_register_one[`MODE_SIG_COMPACT] & ~tdi_init_loaded));
  assign stop_select = (enables[`EN_SEL_A] & sel_a_empty) | (enables[`EN_SEL_B] & sel_b_empty);
  assign stop_length = enables[`EN_LENGTH] & (~length_loaded | length_terminal);
  assign stop_clock = stop_tdo | stop_tdi | stop_select | stop_length;

  // ----------------------------------------
  // Test clock generation
  // ----------------------------------------
  assign rise = ~clock_phase & ~stop_clock;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_phase <= 1'b0;
      clock_enable <= 1'b0;
    end else if (clock_phase) begin
      clock_phase <= 1'b0;
    end else begin
      clock_enable <= ~stop_clock;
      clock_phase <= ~stop_clock;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_clock <= 1'b0;
      shift_strobe <= 1'b0;
      half_swap <= 1'b0;
    end else begin
      test_clock <= rise | freeze_active;
      shift_strobe <= rise;
      half_swap <= swap;
    end
  end

  // ----------------------------------------
  // Length and bit counters
  // ----------------------------------------
  scan_length_counters #(
    .LENGTH_WIDTH(LENGTH_WIDTH)
  ) counters (
    .pclk(pclk),
    .presetn(presetn),
    .load(length_load),
    .load_value(pwdata[LENGTH_WIDTH-1:0]),
    .length_enable(enables[`EN_LENGTH]),
    .step(rise),
    .scan_length_counter(length_count),
    .loaded(length_loaded),
    .terminal(length_terminal),
    .bit_in_byte_counter(bit_count),
    .half_swap(swap)
  );

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign tdo_space_event = mode_register_one[`MODE_TDO_NOT_FULL_IE] & ~tdo_full;
  assign tdi_data_event = mode_register_one[`MODE_TDI_NOT_EMPTY_IE] & ~tdi_empty;
  assign length_event = mode_register_one[`MODE_LENGTH_IE] & (~length_loaded | length_terminal);

  always @* begin
    next_interrupt = tdo_space_event | tdi_data_event | length_event;
  end

  // ----------------------------------------
  // Host wait
  // ----------------------------------------
  assign read_hold = read_sync_busy
    | (tdi_empty & (reg_select == `SEL_TDI));
  assign write_hold = write_sync_busy
    | (tdo_full & (reg_select == `SEL_TDO))
    | (sel_a_full & (reg_select == `SEL_MODE_A))
    | (sel_b_full & (reg_select == `SEL_MODE_B));

  always @* begin
    next_host_wait = 1'b1;
    if (host_cycle) begin
      if (host_read) begin
        next_host_wait = read_hold;
      end else begin
        next_host_wait = write_hold;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt <= 1'b0;
      host_wait <= 1'b1;
    end else begin
      interrupt <= next_interrupt;
      host_wait <= next_host_wait;
    end
  end

  // ----------------------------------------
  // Shifter enable and mode copies
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_enable <= 1'b0;
      tdi_enable <= 1'b0;
      sel_a_enable <= 1'b0;
      sel_b_enable <= 1'b0;
      pattern_generator_mode <= 1'b0;
      signature_compaction_mode <= 1'b0;
    end else begin
      tdo_enable <= enables[`EN_TDO];
      tdi_enable <= enables[`EN_TDI];
      sel_a_enable <= enables[`EN_SEL_A];
      sel_b_enable <= enables[`EN_SEL_B];
      pattern_generator_mode <= mode_register_one[`MODE_PATTERN_GEN];
      signature_compaction_mode <= mode_register_one[`MODE_SIG_COMPACT];
    end
  end

endmodule // scan_clock_gating_control

`default_nettype wire

// ---- testbench/scan_clock_sva.sv ----
// Assertions on the ports of the scan test clock gating block
`timescale 1ns/10ps
`default_nettype none
module scan_clock_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and host
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic host_cycle,
  input wire logic host_read,
  input wire logic [2:0] reg_select,
  input wire logic write_sync_busy,
  input wire logic read_sync_busy,
  input wire logic host_wait,
  // Shifter status and enables
  input wire logic tdo_full,
  input wire logic tdo_empty,
  input wire logic tdi_full,
  input wire logic tdi_empty,
  input wire logic sel_a_full,
  input wire logic sel_a_empty,
  input wire logic sel_b_full,
  input wire logic sel_a_enable,
  input wire logic tdo_enable,
  input wire logic tdi_enable,
  // Freeze pin and clock outputs
  input wire logic sample_hold_input,
  input wire logic shift_strobe,
  input wire logic half_swap,
  input wire logic test_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic want_wait = !host_cycle | (host_read ? (read_sync_busy | (tdi_empty && reg_select == 3'h1)) :
    (write_sync_busy | (tdo_full && reg_select == 3'h0) | (sel_a_full && reg_select == 3'h2) |
    (sel_b_full && reg_select == 3'h3)));
  chk_wait_follows: assert property ($past(presetn) |-> host_wait == $past(want_wait))
    else $error("host wait wrong");
  chk_high_one: assert property ($rose(test_clock) && !sample_hold_input && !$past(sample_hold_input)
    && !$past(sample_hold_input, 2) && !$past(sample_hold_input, 3) |=> !test_clock)
    else $error("test clock high too long");
  chk_strobe_rise: assert property (shift_strobe |-> test_clock && !$past(test_clock))
    else $error("strobe without clock rise");
  chk_strobe_single: assert property (shift_strobe |=> !shift_strobe)
    else $error("strobe too long");
  chk_swap_strobe: assert property (half_swap |-> shift_strobe)
    else $error("swap without clock rise");
  chk_tdo_stop: assert property (tdo_enable && $past(tdo_enable) && $past(tdo_empty) && $past(tdo_empty, 2)
    |-> !shift_strobe) else $error("clock with tdo empty");
  chk_tdi_stop: assert property (tdi_enable && $past(tdi_enable) && $past(tdi_full) && $past(tdi_full, 2)
    |-> !shift_strobe) else $error("clock with tdi full");
  chk_sel_stop: assert property (sel_a_enable && $past(sel_a_enable) && $past(sel_a_empty)
    && $past(sel_a_empty, 2) |-> !shift_strobe) else $error("clock with select empty");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  cov_swap: cover property (half_swap);
  cov_strobe: cover property (shift_strobe);
  cov_ready: cover property (host_cycle && !host_wait);
endmodule // scan_clock_sva
`default_nettype wire

// ---- testbench/scan_chain_model.sv ----
// Scan chain model counting test clock rises
`timescale 1ns/10ps
`default_nettype none
module scan_chain_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic test_clock,
  output logic [15:0] rises
);
  logic last_clock;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_clock <= 1'b0;
      rises <= 16'h0000;
    end else begin
      last_clock <= test_clock;
      if (test_clock && !last_clock) begin
        rises <= rises + 16'h0001;
      end
    end
  end
endmodule // scan_chain_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Top testbench of the scan test clock gating block
`timescale 1ns/10ps
`default_nettype none
`include "scan_clock_consts.vh"
`define check(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, host_cycle = 0, host_read = 0;
  logic write_sync_busy = 0, read_sync_busy = 0, sample_hold_input = 0, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [9:0] st = 10'h090;
  logic [2:0] reg_select = 0;
  logic pready, pslverr, host_wait, tdo_enable, tdi_enable, sel_a_enable, shift_strobe, half_swap;
  logic test_clock, interrupt, sel_b_enable, pattern_generator_mode, signature_compaction_mode;
  logic [15:0] rises, base;
  int failures = 0, num_checks = 0, swaps = 0, i;
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) if (half_swap === 1'b1) swaps++;
  scan_clock_gating_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tdo_full(st[9]), .tdo_empty(st[8]), .tdo_seed_loaded(st[7]), .tdi_full(st[6]), .tdi_empty(st[5]),
    .tdi_init_loaded(st[4]), .sel_a_full(st[3]), .sel_a_empty(st[2]), .sel_b_full(st[1]), .sel_b_empty(st[0]),
    .host_cycle(host_cycle), .host_read(host_read), .reg_select(reg_select), .write_sync_busy(write_sync_busy),
    .read_sync_busy(read_sync_busy), .host_wait(host_wait), .sample_hold_input(sample_hold_input),
    .tdo_enable(tdo_enable), .tdi_enable(tdi_enable), .sel_a_enable(sel_a_enable), .sel_b_enable(sel_b_enable),
    .pattern_generator_mode(pattern_generator_mode), .signature_compaction_mode(signature_compaction_mode),
    .shift_strobe(shift_strobe),
    .half_swap(half_swap), .test_clock(test_clock), .interrupt(interrupt));
  scan_chain_model u_chain (.pclk(pclk), .presetn(presetn), .test_clock(test_clock), .rises(rises));
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(0, a, 0);
    `check("read data", e, rd & m)
  endtask
  task automatic run_case(input logic [7:0] mode, input logic [4:0] en, input logic [9:0] stv, input logic runs);
    st <= stv;
    apb(1, `OFS_MODE_ONE, {24'h0, mode});
    apb(1, `OFS_ENABLES, {27'h0, en});
    step(4);
    base = rises;
    step(20);
    `check("enable copies", {mode[4:3], en[3:0]}, {pattern_generator_mode, signature_compaction_mode, sel_b_enable,
      sel_a_enable, tdi_enable, tdo_enable})
    `check("clock runs", runs, rises != base)
  endtask
  task automatic int_case(input logic [7:0] mode, input logic [9:0] stv, input logic e);
    st <= stv;
    apb(1, `OFS_MODE_ONE, {24'h0, mode});
    step(3);
    `check("interrupt", e, interrupt)
  endtask
  initial begin
    step(5000);
    failures++;
    print_verdict();
  end
  initial begin
    step(2);
    presetn <= 1;
    rdchk(`OFS_MODE_ONE, 0, 32'hffffffff);
    rdchk(`OFS_ENABLES, 0, 32'hffffffff);
    apb(0, 32'h010, 0);
    `check("unmapped error", 1'b1, err)
    int_case(8'h20, 10'h090, 1);
    run_case(8'h00, 5'h00, 10'h090, 1);
    run_case(8'h00, 5'h01, 10'h190, 0);
    run_case(8'h00, 5'h01, 10'h090, 1);
    run_case(8'h10, 5'h01, 10'h010, 0);
    run_case(8'h10, 5'h01, 10'h090, 1);
    run_case(8'h00, 5'h02, 10'h0d0, 0);
    run_case(8'h08, 5'h02, 10'h080, 0);
    run_case(8'h00, 5'h04, 10'h094, 0);
    run_case(8'h00, 5'h08, 10'h091, 0);
    run_case(8'h00, 5'h10, 10'h090, 0);
    base = rises;
    apb(1, `OFS_SCAN_LENGTH, 3);
    apb(1, `OFS_ENABLES, 32'h11);
    step(30);
    `check("rises at length 3", 16'h0003, rises - base)
    rdchk(`OFS_SCAN_LENGTH, 0, 32'hffffffff);
    rdchk(`OFS_STATUS, 32'h4, 32'h74);
    base = rises;
    swaps = 0;
    apb(1, `OFS_SCAN_LENGTH, 11);
    step(40);
    `check("rises at length 11", 16'h000b, rises - base)
    `check("half swaps", 2, swaps)
    run_case(8'h04, 5'h00, 10'h090, 1);
    run_case(8'h04, 5'h01, 10'h190, 0);
    sample_hold_input <= 1;
    step(5);
    `check("frozen clock", 1'b1, test_clock)
    apb(1, `OFS_MODE_ONE, 0);
    step(5);
    `check("freeze removed", 1'b0, test_clock)
    sample_hold_input <= 0;
    int_case(8'h20, 10'h090, 1);
    int_case(8'h80, 10'h090, 1);
    int_case(8'h80, 10'h290, 0);
    int_case(8'h40, 10'h090, 1);
    int_case(8'h40, 10'h0b0, 0);
    int_case(8'h00, 10'h090, 0);
    host_cycle <= 1;
    for (i = 0; i < 32; i++) begin
      host_read <= i[3];
      reg_select <= {1'b0, i[1:0]};
      write_sync_busy <= i[4];
      read_sync_busy <= i[4];
      st <= i[2] ? 10'h36a : 10'h090;
      step(2);
      `check("host wait", i[4] | (i[2] & (i[3] ? i[1:0] == 2'h1 : i[1:0] != 2'h1)), host_wait)
    end
    host_cycle <= 0;
    step(2);
    `check("idle wait", 1'b1, host_wait)
    print_verdict();
  end
endmodule // tb
bind scan_clock_gating_control scan_clock_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .host_cycle(host_cycle), .host_read(host_read), .reg_select(reg_select),
  .write_sync_busy(write_sync_busy), .read_sync_busy(read_sync_busy), .host_wait(host_wait),
  .tdo_full(tdo_full), .tdo_empty(tdo_empty), .tdi_full(tdi_full), .tdi_empty(tdi_empty),
  .sel_a_full(sel_a_full), .sel_a_empty(sel_a_empty), .sel_b_full(sel_b_full), .sel_a_enable(sel_a_enable),
  .tdo_enable(tdo_enable), .tdi_enable(tdi_enable), .sample_hold_input(sample_hold_input),
  .shift_strobe(shift_strobe), .half_swap(half_swap), .test_clock(test_clock));
`default_nettype wire
